//--- design/sac_adc_ctrl.sv
// Behaviour
// - falling start input begins a conversion; ignored here while nap or sleep is set
// - start edges ignored while converting
// - busy low during conversion, else high
// - SAR decides bits MSB to LSB
// - full word loaded into output latches
// - result bus bit thirteen is MSB
// - flag high, MSB low means over-range
// - two select pins choose four spans
// - nap input low enters nap, reference on
// - sleep input low enters deepest power-down
// - result presented in two's complement
// - flag on most negative code or overrange
// - conversion completes in 260ns
//
// The register offsets and the APB slave port were left to the implementer.
`default_nettype none
module sac_adc_ctrl (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic conversion_start_n,
    input wire logic span_select0,
    input wire logic span_select1,
    input wire logic nap_n,
    input wire logic deep_powerdown_n,
    input wire logic compAbove,
    input wire logic overRangeCmp,
    output logic [13:0] dacCode,
    output logic busy,
    output logic [13:0] result_bus,
    output logic range_exceeded_flag,
    output logic [1:0] spanLevel,
    output logic napMode,
    output logic sleepMode,
    output logic refEnable,
    output logic irq,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    typedef struct packed {
        sac_pkg::sac_state_type state;
        logic [4:0] cnt;
        logic startPrev;
        logic busy;
        logic sarStart;
        logic [13:0] result;
        logic flag;
        logic nap;
        logic sleep;
        logic refEn;
        logic [1:0] span;
        logic [sac_pkg::INT_BITS-1:0] intStat;
        logic [sac_pkg::INT_BITS-1:0] intMask;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } sac_ctrl_type;

    sac_ctrl_type s_r;
    sac_ctrl_type s_nxt;
    logic [13:0] sarCode;

    function automatic logic addrHit(input logic [7:0] addr, input logic [7:0] ofs);
        addrHit = (addr == ofs);
    endfunction

    function automatic logic [1:0] spanOf(input logic sel0, input logic sel1);
        // Both high 0 dB, sel0 only -3 dB, sel1 only -6 dB, none -9 dB
        spanOf = {~sel0, ~sel1};
    endfunction

    sac_sar_engine #(
        .BITS(sac_pkg::SAR_BITS)
    ) u_sar (
        .clk(clk),
        .rst_b(rst_b),
        .sarStart(s_r.sarStart),
        .compAbove(compAbove),
        .trialCode(sarCode)
    );

    always_comb begin
        logic startEdge;
        logic softStart;
        logic apbDone;
        logic mapped;
        logic [sac_pkg::INT_BITS-1:0] evSet;
        logic [13:0] twos;
        startEdge = 1'b0;
        softStart = 1'b0;
        apbDone = 1'b0;
        mapped = 1'b0;
        evSet = '0;
        twos = '0;
        s_nxt = s_r;
        s_nxt.sarStart = 1'b0;
        s_nxt.startPrev = conversion_start_n;
        s_nxt.span = spanOf(span_select0, span_select1);

        apbDone = psel && penable && s_r.pready;
        softStart = apbDone && pwrite && addrHit(paddr, sac_pkg::OFS_CTRL)
            && pwdata[sac_pkg::CTRL_SOFT_START];
        startEdge = (s_r.startPrev && !conversion_start_n) || softStart;

        case (s_r.state)
            sac_pkg::ST_IDLE: begin
                // Power state changes only between conversions
                s_nxt.nap = !nap_n;
                s_nxt.sleep = !deep_powerdown_n;
                s_nxt.refEn = deep_powerdown_n;
                if (startEdge) begin
                    if (s_r.nap || s_r.sleep) begin
                        evSet[sac_pkg::INT_IGNORED] = 1'b1;
                    end else begin
                        s_nxt.state = sac_pkg::ST_CONV;
                        s_nxt.cnt = '0;
                        s_nxt.busy = 1'b0;
                    end
                end
            end
            sac_pkg::ST_CONV: begin
                if (startEdge) begin
                    evSet[sac_pkg::INT_IGNORED] = 1'b1;
                end
                s_nxt.cnt = s_r.cnt + 5'h01;
                if (s_r.cnt == sac_pkg::LAUNCH_CNT) begin
                    s_nxt.sarStart = 1'b1;
                end
                if (s_r.cnt == sac_pkg::LATCH_CNT) begin
                    // Offset binary to two's complement
                    twos = {~sarCode[13], sarCode[12:0]};
                    s_nxt.result = twos;
                    s_nxt.flag = overRangeCmp || (twos == sac_pkg::NEG_FULL_CODE);
                    evSet[sac_pkg::INT_RANGE] = s_nxt.flag;
                end
                if (s_r.cnt == sac_pkg::LAST_CNT) begin
                    // Data settled one cycle before busy rises
                    s_nxt.busy = 1'b1;
                    s_nxt.state = sac_pkg::ST_IDLE;
                    evSet[sac_pkg::INT_DONE] = 1'b1;
                end
            end
            default: begin
                s_nxt.state = sac_pkg::ST_IDLE;
                s_nxt.busy = 1'b1;
            end
        endcase

        // APB slave: answer in the access phase
        s_nxt.pready = psel && !penable;
        mapped = addrHit(paddr, sac_pkg::OFS_CTRL) || addrHit(paddr, sac_pkg::OFS_STATUS)
            || addrHit(paddr, sac_pkg::OFS_RESULT) || addrHit(paddr, sac_pkg::OFS_INT_STAT)
            || addrHit(paddr, sac_pkg::OFS_INT_MASK);
        if (psel && !penable) begin
            s_nxt.pslverr = !mapped;
            s_nxt.prdata = '0;
            if (!pwrite) begin
                if (addrHit(paddr, sac_pkg::OFS_STATUS)) begin
                    s_nxt.prdata[sac_pkg::STAT_BUSY] = s_r.busy;
                    s_nxt.prdata[sac_pkg::STAT_NAP] = s_r.nap;
                    s_nxt.prdata[sac_pkg::STAT_SLEEP] = s_r.sleep;
                    s_nxt.prdata[sac_pkg::STAT_SPAN_LO +: 2] = s_r.span;
                end else if (addrHit(paddr, sac_pkg::OFS_RESULT)) begin
                    s_nxt.prdata[13:0] = s_r.result;
                    s_nxt.prdata[sac_pkg::RES_FLAG] = s_r.flag;
                end else if (addrHit(paddr, sac_pkg::OFS_INT_STAT)) begin
                    s_nxt.prdata[sac_pkg::INT_BITS-1:0] = s_r.intStat;
                end else if (addrHit(paddr, sac_pkg::OFS_INT_MASK)) begin
                    s_nxt.prdata[sac_pkg::INT_BITS-1:0] = s_r.intMask;
                end
            end
        end else if (apbDone) begin
            s_nxt.pslverr = 1'b0;
        end

        if (apbDone && pwrite && addrHit(paddr, sac_pkg::OFS_INT_MASK)) begin
            s_nxt.intMask = pwdata[sac_pkg::INT_BITS-1:0];
        end
        // Read clears; a new event in the same cycle survives
        if (apbDone && !pwrite && addrHit(paddr, sac_pkg::OFS_INT_STAT)) begin
            s_nxt.intStat = evSet;
        end else begin
            s_nxt.intStat = s_r.intStat | evSet;
        end
        s_nxt.irq = |(s_nxt.intStat & s_nxt.intMask);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
            s_r.state <= sac_pkg::ST_IDLE;
            s_r.startPrev <= 1'b1;
            s_r.busy <= 1'b1;
            s_r.refEn <= 1'b1;
            s_r.result <= sac_pkg::RESULT_RST;
            s_r.intMask <= sac_pkg::INT_MASK_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign dacCode = sarCode;
    assign busy = s_r.busy;
    assign result_bus = s_r.result;
    assign range_exceeded_flag = s_r.flag;
    assign spanLevel = s_r.span;
    assign napMode = s_r.nap;
    assign sleepMode = s_r.sleep;
    assign refEnable = s_r.refEn;
    assign irq = s_r.irq;
    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
endmodule
`default_nettype wire

//--- design/sac_pkg.sv
`default_nettype none
package sac_pkg;
    // Converter geometry
    localparam int SAR_BITS = 14;
    localparam logic [13:0] NEG_FULL_CODE = 14'h2000;

    // Conversion timing, 100 MHz core clock
    localparam int CLK_PERIOD_NS = 10;
    localparam int CONV_TIME_NS = 260;
    localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam logic [4:0] LAST_CNT = 5'(CONV_CYCLES - 1);
    localparam logic [4:0] LATCH_CNT = 5'(CONV_CYCLES - 2);
    localparam logic [4:0] LAUNCH_CNT = 5'(CONV_CYCLES - SAR_BITS - 4);

    // APB register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_RESULT = 8'h08;
    localparam logic [7:0] OFS_INT_STAT = 8'h0c;
    localparam logic [7:0] OFS_INT_MASK = 8'h10;

    // Control register fields
    localparam int CTRL_SOFT_START = 0;

    // Status register fields
    localparam int STAT_BUSY = 0;
    localparam int STAT_NAP = 1;
    localparam int STAT_SLEEP = 2;
    localparam int STAT_SPAN_LO = 4;

    // Result register fields
    localparam int RES_FLAG = 16;

    // Interrupt status and mask fields
    localparam int INT_DONE = 0;
    localparam int INT_IGNORED = 1;
    localparam int INT_RANGE = 2;
    localparam int INT_BITS = 3;

    // Reset values
    localparam logic [2:0] INT_MASK_RST = 3'h0;
    localparam logic [13:0] RESULT_RST = 14'h0000;

    // Span levels: 0 dB, -3 dB, -6 dB, -9 dB
    typedef enum logic [1:0] {
        SPAN_0DB = 2'b00,
        SPAN_M3DB = 2'b01,
        SPAN_M6DB = 2'b10,
        SPAN_M9DB = 2'b11
    } sac_span_type;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_CONV = 1'b1
    } sac_state_type;
endpackage
`default_nettype wire

//--- design/sac_sar_engine.sv
`default_nettype none
module sac_sar_engine #(
    parameter int BITS = 14
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sarStart,
    input wire logic compAbove,
    output logic [BITS-1:0] trialCode
);
    typedef struct packed {
        logic active;
        logic [$clog2(BITS)-1:0] bitIdx;
        logic [BITS-1:0] code;
    } sac_sar_type;

    sac_sar_type s_r;
    sac_sar_type s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (sarStart) begin
            // First trial is the MSB at half scale
            s_nxt.active = 1'b1;
            s_nxt.bitIdx = ($clog2(BITS))'(BITS - 1);
            s_nxt.code = '0;
            s_nxt.code[BITS-1] = 1'b1;
        end else if (s_r.active) begin
            // One decision per step, MSB down to LSB
            if (!compAbove) begin
                s_nxt.code[s_r.bitIdx] = 1'b0;
            end
            if (s_r.bitIdx == '0) begin
                s_nxt.active = 1'b0;
            end else begin
                s_nxt.bitIdx = s_r.bitIdx - 1'b1;
                s_nxt.code[s_r.bitIdx - 1'b1] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign trialCode = s_r.code;
endmodule
`default_nettype wire

//--- tb/sac_far_model.sv
`default_nettype none
module sac_far_model (
    input wire logic clk,
    input wire logic busy,
    input wire logic [13:0] dacCode,
    input wire logic [13:0] result_bus,
    input wire logic [13:0] target,
    output logic compAbove,
    output logic [13:0] capData
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busyPrev = 1'b1;
    // Held input keeps a trial bit while it is at or above the trial code
    assign compAbove = (target >= dacCode);
    // Reader takes the word on the rising busy edge
    always @(posedge clk) begin
        busyPrev <= busy;
        if (busy && !busyPrev) capData <= result_bus;
    end
endmodule
`default_nettype wire

//--- tb/sac_adc_props.sv
`default_nettype none
module sac_adc_props (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic conversion_start_n,
    input wire logic span_select0,
    input wire logic span_select1,
    input wire logic nap_n,
    input wire logic deep_powerdown_n,
    input wire logic overRangeCmp,
    input wire logic [13:0] dacCode,
    input wire logic busy,
    input wire logic [13:0] result_bus,
    input wire logic range_exceeded_flag,
    input wire logic [1:0] spanLevel,
    input wire logic napMode,
    input wire logic sleepMode,
    input wire logic refEnable
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] lowCnt_r;
    logic [5:0] lowCnt_nxt;
    assign lowCnt_nxt = busy ? 6'h00 : lowCnt_r + 6'h01;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) lowCnt_r <= 6'h00;
        else lowCnt_r <= lowCnt_nxt;
    end
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    a_busy_len: assert property ($rose(busy) |-> lowCnt_r == 6'h1a)
        else $error("busy low time wrong");
    a_start_take: assert property ($fell(conversion_start_n) && busy && nap_n
        && deep_powerdown_n && !napMode && !sleepMode |=> !busy)
        else $error("start edge not taken");
    a_result_busy: assert property ($changed(result_bus) |-> !busy)
        else $error("result changed while idle");
    a_data_first: assert property ($rose(busy) |-> $stable(result_bus)
        && $stable(range_exceeded_flag))
        else $error("data not settled at busy rise");
    a_msb_first: assert property ($fell(busy) |-> ##10 dacCode == 14'h2000)
        else $error("first trial not the msb");
    a_flag_rule: assert property ($rose(busy) |-> range_exceeded_flag ==
        ($past(overRangeCmp, 2) || result_bus == 14'h2000))
        else $error("range flag wrong");
    a_span_map: assert property (spanLevel ==
        {~$past(span_select0), ~$past(span_select1)})
        else $error("span level wrong");
    a_nap_ref: assert property (napMode && !sleepMode |-> refEnable)
        else $error("reference off in nap");
    a_sleep_ref: assert property (sleepMode |-> !refEnable)
        else $error("reference on in sleep");
endmodule
`default_nettype wire

//--- tb/sac_adc_ctrl_test.sv
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; \
    $display("BAD %0t got %h want %h", $time, (a), (e)); end end
module sac_adc_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_b = 1'b0, conversion_start_n = 1'b1, span_select0 = 1'b1;
    logic span_select1 = 1'b1, nap_n = 1'b1, deep_powerdown_n = 1'b1, overRangeCmp = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, compAbove, busy, range_exceeded_flag;
    logic napMode, sleepMode, refEnable, irq, pready, pslverr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [13:0] target = 14'h0, dacCode, result_bus, capData, ex;
    logic [1:0] spanLevel;
    int n_fail = 0, compares = 0;
    logic [13:0] tTab [4] = '{14'h3fff, 14'h0000, 14'h2000, 14'h1555};
    always #5 clk = ~clk;
    sac_adc_ctrl dut (.clk, .rst_b, .conversion_start_n, .span_select0, .span_select1, .nap_n,
        .deep_powerdown_n, .compAbove, .overRangeCmp, .dacCode, .busy, .result_bus,
        .range_exceeded_flag, .spanLevel, .napMode, .sleepMode, .refEnable, .irq, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
    sac_far_model far (.clk, .busy, .dacCode, .result_bus, .target, .compAbove, .capData);
    task automatic finish_test;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic guard(ref int n);
        n++;
        if (n > 60) begin
            n_fail++;
            finish_test();
        end
        @(posedge clk);
    endtask
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d, logic [31:0] e, logic ee);
        int n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) guard(n);
        if (!wr) `CHK(prdata, e);
        `CHK(pslverr, ee);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wait_busy(logic v);
        int n = 0;
        while (busy !== v) guard(n);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        apb(1'b0, sac_pkg::OFS_INT_MASK, 32'h0, 32'h0, 1'b0);
        apb(1'b0, 8'h40, 32'h0, 32'h0, 1'b1);
        apb(1'b1, sac_pkg::OFS_INT_MASK, 32'h1, 32'h0, 1'b0);
        for (int i = 0; i < 4; i++) begin
            target <= tTab[i];
            overRangeCmp <= (i == 0);
            ex = {~tTab[i][13], tTab[i][12:0]};
            conversion_start_n <= 1'b0;
            wait_busy(1'b0);
            repeat (3) @(posedge clk);
            conversion_start_n <= 1'b1;
            repeat (3) @(posedge clk);
            conversion_start_n <= (i != 1);
            wait_busy(1'b1);
            conversion_start_n <= 1'b1;
            repeat (10) @(posedge clk);
            `CHK(result_bus, ex);
            `CHK(capData, ex);
            `CHK(range_exceeded_flag, (i == 0) || ex == 14'h2000);
            apb(1'b0, sac_pkg::OFS_RESULT, 32'h0,
                {15'h0, (i == 0) || ex == 14'h2000, 2'h0, ex}, 1'b0);
            `CHK(irq, 1'b1);
            apb(1'b0, sac_pkg::OFS_INT_STAT, 32'h0, {(i < 2), (i == 1), 1'b1}, 1'b0);
            @(posedge clk);
            `CHK(irq, 1'b0);
        end
        for (int i = 0; i < 4; i++) begin
            {span_select1, span_select0} <= 2'(i);
            @(posedge clk);
            apb(1'b0, sac_pkg::OFS_STATUS, 32'h0, {~i[0], ~i[1], 4'h1}, 1'b0);
        end
        nap_n <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK(napMode, 1'b1);
        conversion_start_n <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK(busy, 1'b1);
        conversion_start_n <= 1'b1;
        nap_n <= 1'b1;
        deep_powerdown_n <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK(sleepMode, 1'b1);
        `CHK(refEnable, 1'b0);
        deep_powerdown_n <= 1'b1;
        apb(1'b0, sac_pkg::OFS_INT_STAT, 32'h0, 32'h2, 1'b0);
        // Soft start, then a second one that lands mid-conversion
        apb(1'b1, sac_pkg::OFS_CTRL, 32'h1, 32'h0, 1'b0);
        wait_busy(1'b0);
        apb(1'b1, sac_pkg::OFS_CTRL, 32'h1, 32'h0, 1'b0);
        wait_busy(1'b1);
        `CHK(result_bus, ex);
        `CHK(range_exceeded_flag, 1'b0);
        apb(1'b0, sac_pkg::OFS_INT_STAT, 32'h0, 32'h3, 1'b0);
        finish_test();
    end
endmodule
bind sac_adc_ctrl sac_adc_props chk (.clk, .rst_b, .conversion_start_n, .span_select0,
    .span_select1, .nap_n, .deep_powerdown_n, .overRangeCmp, .dacCode, .busy, .result_bus,
    .range_exceeded_flag, .spanLevel, .napMode, .sleepMode, .refEnable);
`default_nettype wire
